// ==== hw/encoder_pkg.sv ====
// Purpose: Shared constants for the tri-state address/data encoder.
// Assumes: 40 MHz mclk; encoder slot rate derived from the nominal oscillator.
// Notes:   Symbol waveform and framing are a fixed house encoding.
package encoder_pkg;

  // ***************************************************************
  // Clock and timing
  // ***************************************************************
  localparam int CLK_HZ          = 40_000_000;
  localparam int CLK_PERIOD_NS   = 25;
  localparam int ENC_OSC_HZ      = 70_000;
  localparam int SLOT_CYCLES     = CLK_HZ / ENC_OSC_HZ;
  localparam int SETTLE_TIME_NS  = 500;
  localparam int SETTLE_CYCLES   = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MAX_LAG_MS      = 150;
  localparam int MAX_LAG_CYCLES  = MAX_LAG_MS * (CLK_HZ / 1000);

  // ***************************************************************
  // Word layout and symbol encoding
  // ***************************************************************
  localparam int ADDR_LINES      = 10;
  localparam int DATA_LINES      = 8;
  localparam int SYMBOLS         = ADDR_LINES + DATA_LINES;
  localparam int WORD_BITS       = 2 * SYMBOLS;
  localparam int WORDS_PER_CYCLE = 3;
  localparam int SLOTS_PER_BIT   = 4;
  localparam int ONE_HIGH_SLOTS  = 3;
  localparam int ZERO_HIGH_SLOTS = 1;
  localparam int SYNC_SLOTS      = 36;
  // Trit code is {level with probe low, level with probe high}
  localparam logic [1:0] TRIT_LOW   = 2'h0;
  localparam logic [1:0] TRIT_FLOAT = 2'h1;
  localparam logic [1:0] TRIT_HIGH  = 2'h3;

  // ***************************************************************
  // APB register map
  // ***************************************************************
  localparam logic [11:0] OFS_CTRL       = 12'h000;
  localparam logic [11:0] OFS_STATUS     = 12'h004;
  localparam logic [11:0] OFS_CYCLES     = 12'h008;
  localparam logic [11:0] OFS_ADDR_TRITS = 12'h00C;
  localparam logic [11:0] OFS_DATA_TRITS = 12'h010;
  localparam int          CTRL_SOFT_GATE = 0;
  localparam int          CTRL_HOLD      = 1;
  localparam logic [1:0]  CTRL_RESET     = 2'h0;

endpackage

// ==== hw/tristate_sampler.sv ====
// Purpose: Classifies each input line as high, low or floating.
// Assumes: A weak pull on every line follows probe; driven lines ignore it.
// Notes:   A line that tracks the probe in both phases is floating.
`timescale 1ns/1ps
module tristate_sampler #(
  parameter int LINES  = encoder_pkg::SYMBOLS,
  parameter int SETTLE = encoder_pkg::SETTLE_CYCLES
) (
  input  wire logic               mclk,
  input  wire logic               reset,
  input  wire logic               start,
  input  wire logic [LINES-1:0]   lines_in,
  output logic                    probe,
  output logic                    done,
  output logic [2*LINES-1:0]      trits
);

  typedef enum logic [1:0] {PH_IDLE, PH_HIGH, PH_LOW} probe_phase_t;

  probe_phase_t       phase_q;
  logic [15:0]        cnt_q;
  logic [LINES-1:0]   high_q;
  logic               settled;

  assign settled = (cnt_q == 16'(SETTLE - 1));

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      phase_q <= PH_IDLE;
      cnt_q   <= 16'h0000;
      probe   <= 1'b0;
      done    <= 1'b0;
      high_q  <= '0;
      trits   <= '0;
    end
    else
    begin
      done <= 1'b0;
      cnt_q <= settled ? 16'h0000 : cnt_q + 16'h0001;
      unique case (phase_q)
        PH_IDLE:
        begin
          cnt_q <= 16'h0000;
          if (start)
          begin
            phase_q <= PH_HIGH;
            probe   <= 1'b1;
          end
        end
        PH_HIGH:
          if (settled)
          begin
            high_q  <= lines_in;
            probe   <= 1'b0;
            phase_q <= PH_LOW;
          end
        PH_LOW:
          if (settled)
          begin
            for (int i = 0; i < LINES; i++)
              trits[2*i +: 2] <= {lines_in[i], high_q[i]}; // RULE5
            done    <= 1'b1;
            phase_q <= PH_IDLE;
          end
      endcase
    end
  end

  a_probe_high_phase: assert property (@(posedge mclk) disable iff (reset)
    (start && phase_q == PH_IDLE) |=> probe [*8]) // RULE5
    else $error("probe not held high during the first settle phase");

  a_float_code: assert property (@(posedge mclk) disable iff (reset)
    done |-> trits[1:0] == {$past(lines_in[0]), high_q[0]}) // RULE5
    else $error("trit code does not match the two probe readings");

endmodule

// ==== hw/word_buffer.sv ====
// Purpose: Small valid/ready buffer between word builder and serializer.
// Assumes: Single clock; depth is a power of two.
// Notes:   Full and empty are exact, so a stalled drain blocks the producer.
`timescale 1ns/1ps
module word_buffer #(
  parameter int WIDTH = encoder_pkg::WORD_BITS,
  parameter int DEPTH = 2
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign in_ready  = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data  = mem[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wr_q] <= in_data;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      wr_q    <= '0;
      rd_q    <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

// ==== hw/tristate_address_data_encoder.sv ====
// Purpose: Tri-state address/data encoder that keys a transmitter.
// Assumes: Inputs synchronous to mclk; APB slave with one wait state.
// Notes:   Power loss is modelled by reset; rf_output is the keying stream.
// Behaviour
// RULE1: Gate high samples address and data, one cycle sends the word three times.
// RULE2: While the gate stays high a new three-word cycle follows at once.
// RULE3: Gate falling mid-cycle lets the cycle finish, then sending stops.
// RULE4: Word carries ten address then eight data symbols, line zero first.
// RULE5: Each input is classified as driven high, driven low or floating.
// RULE6: Receiver takes a floating data symbol as low.
// RULE7: Data lines are captured when the gate rises and those values sent.
// RULE8: Data lines are sampled again at the start of each cycle.
// RULE9: A data change shows only from the next cycle, within 150 ms.
// RULE10: Receiver accepts only when every address symbol matches exactly.
// RULE11: On address mismatch the receiver keeps its outputs unchanged.
// RULE12: On a match the receiver reproduces the sent data states.
// RULE13: Sending goes on until gate is low or power is removed.
// RULE14: The packet leaves as one serial bit stream keying the carrier.
// RULE15: Gate tied high starts sending right after power-up.
// RULE16: Symbol waveform and framing follow one fixed shared encoding.
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
module tristate_address_data_encoder #(
  parameter int SLOT_DIV   = encoder_pkg::SLOT_CYCLES,
  parameter int LAG_CYCLES = encoder_pkg::MAX_LAG_CYCLES,
  parameter int SETTLE     = encoder_pkg::SETTLE_CYCLES
) (
  input  wire logic                               mclk,
  input  wire logic                               reset,
  input  wire logic                               send_gate,
  input  wire logic [encoder_pkg::ADDR_LINES-1:0] code_select_lines,
  input  wire logic [encoder_pkg::DATA_LINES-1:0] payload_inputs,
  output logic                                    pull_probe,
  output logic                                    rf_output,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [11:0]                        paddr,
  input  wire logic [31:0]                        pwdata,
  output logic [31:0]                             prdata,
  output logic                                    pready,
  output logic                                    pslverr
);

  localparam int NW = encoder_pkg::WORD_BITS;
  localparam int NS = encoder_pkg::SYMBOLS;
  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_LOAD, ST_SEND} cycle_state_t;
  // ***************************************************************
  // Helpers
  // ***************************************************************
  // Puts symbol i at bits 2i and 2i+1, probe-low reading first on air
  function automatic logic [NW-1:0] trits_to_word(input logic [NW-1:0] t);
    logic [NW-1:0] w;
    w = '0;
    for (int i = 0; i < NS; i++)
      w[2*i +: 2] = {t[2*i], t[2*i+1]};
    return w;
  endfunction

  function automatic logic is_reg(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction

  // ***************************************************************
  // Declarations
  // ***************************************************************
  cycle_state_t     state_q;
  logic [1:0]       pushes_q;
  logic [1:0]       words_done_q;
  logic [NW-1:0]    trits_q;
  logic [NW-1:0]    samp_trits;
  logic             samp_done;
  logic             samp_start;
  logic             gate_eff;
  logic             cycle_end;
  logic [1:0]       ctrl_q;
  logic [31:0]      cycles_q;
  logic [31:0]      lag_cnt_q;
  logic             buf_in_valid;
  logic             buf_in_ready;
  logic             buf_out_valid;
  logic             buf_out_ready;
  logic [NW-1:0]    buf_out_data;
  logic             ser_busy_q;
  logic             in_sync_q;
  logic [5:0]       sync_q;
  logic [5:0]       bit_idx_q;
  logic [1:0]       slot_q;
  logic [15:0]      div_q;
  logic             slot_tick;
  logic             word_done;
  logic [NW-1:0]    cur_word_q;
  logic             cur_bit;
  logic             apb_access;
  logic             apb_commit;
  logic             addr_ok;
  logic [31:0]      rd_mux;
  assign gate_eff   = send_gate || ctrl_q[encoder_pkg::CTRL_SOFT_GATE];
  assign samp_start = (state_q == ST_IDLE && gate_eff) ||
                      (state_q == ST_SEND && cycle_end && gate_eff);
  assign cycle_end  = word_done && words_done_q == 2'(encoder_pkg::WORDS_PER_CYCLE - 1);

  // ***************************************************************
  // Input classification
  // ***************************************************************
  tristate_sampler #(
    .LINES  (NS),
    .SETTLE (SETTLE)
  ) u_sampler (
    .mclk     (mclk),
    .reset    (reset),
    .start    (samp_start),
    .lines_in ({payload_inputs, code_select_lines}),
    .probe    (pull_probe),
    .done     (samp_done),
    .trits    (samp_trits)
  );

  // ***************************************************************
  // Cycle sequencer
  // ***************************************************************
  // Reset leaves ST_IDLE, so a gate tied high starts a cycle at once
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      state_q  <= ST_IDLE;
      pushes_q <= 2'h0;
      trits_q  <= '0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
          if (gate_eff)
            state_q <= ST_SAMPLE; // RULE1 RULE7 RULE15
        ST_SAMPLE:
          if (samp_done)
          begin
            trits_q  <= samp_trits; // RULE7 RULE8 RULE9
            pushes_q <= 2'h0;
            state_q  <= ST_LOAD;
          end
        ST_LOAD:
          if (buf_in_ready)
          begin
            pushes_q <= pushes_q + 2'h1;
            if (pushes_q == 2'(encoder_pkg::WORDS_PER_CYCLE - 1))
              state_q <= ST_SEND; // RULE1
          end
        ST_SEND:
          if (cycle_end)
            state_q <= gate_eff ? ST_SAMPLE : ST_IDLE; // RULE2 RULE3 RULE13
      endcase
    end
  end

  assign buf_in_valid = (state_q == ST_LOAD);
  // Counts finished words so the cycle always closes after the third
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      words_done_q <= 2'h0;
    else if (cycle_end)
      words_done_q <= 2'h0;
    else if (word_done)
      words_done_q <= words_done_q + 2'h1;
  end

  // Length of the running cycle, bounds the data-to-air lag
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      lag_cnt_q <= 32'h0000_0000;
      cycles_q  <= 32'h0000_0000;
    end
    else
    begin
      if (samp_start || state_q == ST_IDLE)
        lag_cnt_q <= 32'h0000_0000;
      else
        lag_cnt_q <= lag_cnt_q + 32'h0000_0001;
      if (cycle_end)
        cycles_q <= cycles_q + 32'h0000_0001;
    end
  end

  // ***************************************************************
  // Word buffer
  // ***************************************************************
  word_buffer #(
    .WIDTH (NW),
    .DEPTH (2)
  ) u_buffer (
    .mclk      (mclk),
    .reset     (reset),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (trits_to_word(trits_q)), // RULE4
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  // Hold stalls the serializer between words; the buffer then fills
  assign buf_out_ready = !ser_busy_q && !ctrl_q[encoder_pkg::CTRL_HOLD];

  // ***************************************************************
  // Serializer
  // ***************************************************************
  assign slot_tick = ser_busy_q && (div_q == 16'(SLOT_DIV - 1));
  assign word_done = slot_tick && !in_sync_q &&
                     slot_q == 2'(encoder_pkg::SLOTS_PER_BIT - 1) &&
                     bit_idx_q == 6'(NW - 1);
  assign cur_bit   = cur_word_q[bit_idx_q];
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      div_q <= 16'h0000;
    else if (!ser_busy_q || slot_tick)
      div_q <= 16'h0000;
    else
      div_q <= div_q + 16'h0001;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      ser_busy_q <= 1'b0;
      in_sync_q  <= 1'b0;
      sync_q     <= 6'h00;
      bit_idx_q  <= 6'h00;
      slot_q     <= 2'h0;
      cur_word_q <= '0;
    end
    else if (!ser_busy_q)
    begin
      if (buf_out_valid && buf_out_ready)
      begin
        cur_word_q <= buf_out_data;
        ser_busy_q <= 1'b1;
        in_sync_q  <= 1'b1;
        sync_q     <= 6'h00;
        bit_idx_q  <= 6'h00;
        slot_q     <= 2'h0;
      end
    end
    else if (slot_tick)
    begin
      if (in_sync_q)
      begin
        if (sync_q == 6'(encoder_pkg::SYNC_SLOTS - 1))
          in_sync_q <= 1'b0; // RULE16
        else
          sync_q <= sync_q + 6'h01;
      end
      else if (slot_q == 2'(encoder_pkg::SLOTS_PER_BIT - 1))
      begin
        slot_q <= 2'h0;
        if (bit_idx_q == 6'(NW - 1))
          ser_busy_q <= 1'b0; // RULE4
        else
          bit_idx_q <= bit_idx_q + 6'h01;
      end
      else
        slot_q <= slot_q + 2'h1;
    end
  end

  // Pulse-width coded bit: wide high for one, narrow high for zero
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      rf_output <= 1'b0;
    else
      rf_output <= ser_busy_q && !in_sync_q &&
                   (slot_q < (cur_bit ? 2'(encoder_pkg::ONE_HIGH_SLOTS)
                                      : 2'(encoder_pkg::ZERO_HIGH_SLOTS))); // RULE14 RULE16
  end

  // ***************************************************************
  // APB slave
  // ***************************************************************
  // One wait state: pready rises in the second access cycle
  assign apb_access = psel && penable;
  assign apb_commit = apb_access && pready;
  assign addr_ok    = is_reg(paddr, encoder_pkg::OFS_CTRL) ||
                      is_reg(paddr, encoder_pkg::OFS_STATUS) ||
                      is_reg(paddr, encoder_pkg::OFS_CYCLES) ||
                      is_reg(paddr, encoder_pkg::OFS_ADDR_TRITS) ||
                      is_reg(paddr, encoder_pkg::OFS_DATA_TRITS);
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (is_reg(paddr, encoder_pkg::OFS_CTRL))
      rd_mux = {30'h0, ctrl_q};
    else if (is_reg(paddr, encoder_pkg::OFS_STATUS))
      rd_mux = {26'h0, buf_out_valid, words_done_q, ser_busy_q, rf_output,
                state_q != ST_IDLE};
    else if (is_reg(paddr, encoder_pkg::OFS_CYCLES))
      rd_mux = cycles_q;
    else if (is_reg(paddr, encoder_pkg::OFS_ADDR_TRITS))
      rd_mux = {12'h000, trits_q[2*encoder_pkg::ADDR_LINES-1:0]};
    else if (is_reg(paddr, encoder_pkg::OFS_DATA_TRITS))
      rd_mux = {16'h0000, trits_q[NW-1:2*encoder_pkg::ADDR_LINES]};
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= apb_access && !pready;
      pslverr <= apb_access && !pready && !addr_ok;
      prdata  <= (apb_access && !pready && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      ctrl_q <= encoder_pkg::CTRL_RESET;
    else if (apb_commit && pwrite && is_reg(paddr, encoder_pkg::OFS_CTRL))
      ctrl_q <= pwdata[1:0];
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  sequence s_cycle_close;
    (state_q == ST_SEND) && cycle_end;
  endsequence
  sequence s_gate_rise;
    (state_q == ST_IDLE) && gate_eff;
  endsequence
  a_gate_starts_cycle: assert property (@(posedge mclk) disable iff (reset)
    s_gate_rise |=> state_q == ST_SAMPLE ##1 u_sampler.probe) // RULE1
    else $error("gate high did not start sampling");
  a_cycle_repeats: assert property (@(posedge mclk) disable iff (reset)
    (s_cycle_close and gate_eff) |=> state_q == ST_SAMPLE) // RULE2
    else $error("cycle did not restart with gate high");
  a_stop_after_cycle: assert property (@(posedge mclk) disable iff (reset)
    (s_cycle_close and !gate_eff) |=> state_q == ST_IDLE ##1 !ser_busy_q) // RULE3
    else $error("sending went on after the gate fell");
  a_three_words: assert property (@(posedge mclk) disable iff (reset)
    (state_q == ST_LOAD && buf_in_ready && pushes_q == 2'h2) |=> state_q == ST_SEND) // RULE1
    else $error("cycle loaded a wrong number of words");
  a_word_length: assert property (@(posedge mclk) disable iff (reset)
    word_done |-> bit_idx_q == 6'(NW - 1) && !in_sync_q && !rf_output) // RULE4
    else $error("word ended at a wrong bit count");
  a_fresh_sample: assert property (@(posedge mclk) disable iff (reset)
    (state_q == ST_SAMPLE && samp_done) |=> trits_q == $past(samp_trits)) // RULE8
    else $error("cycle did not use the fresh sample");
  a_lag_bound: assert property (@(posedge mclk) disable iff (reset)
    lag_cnt_q <= 32'(LAG_CYCLES)) // RULE9
    else $error("cycle longer than the allowed data lag");
  a_quiet_idle: assert property (@(posedge mclk) disable iff (reset)
    (state_q == ST_IDLE && !ser_busy_q) |=> !rf_output) // RULE13 RULE14
    else $error("rf output keyed while idle");

endmodule

// ==== verif/rx_decoder_model.sv ====
// Purpose: Receiver/decoder model that reads the keying stream.
// Assumes: Pulse-width bits; a long low gap marks the start of a word.
// Notes:   data_out changes only on a whole word whose address matches.
`timescale 1ns/1ps
module rx_decoder_model #(
  parameter int SLOT = 4
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        rf_in,
  input  wire logic [19:0] local_codes,
  output logic             match,
  output logic [7:0]       data_out,
  output logic [7:0]       words,
  output logic [35:0]      last_word
);
  // ****************
  // Pulse decoding
  // ****************
  int          hi;
  int          lo;
  int          nb;
  logic [35:0] sh;
  logic        ok;

  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      hi = 0;
      lo = 0;
      nb = 0;
      match <= 1'b0;
      data_out <= 8'h00;
      words <= 8'h00;
      last_word <= 36'h0;
    end
    else if (rf_in)
    begin
      hi = hi + 1;
      lo = 0;
    end
    else
    begin
      lo = lo + 1;
      if (lo > 6 * SLOT)
        nb = 0;
      if (hi > 0)
      begin
        sh = {sh[34:0], hi > 2 * SLOT};
        hi = 0;
        nb = nb + 1;
        if (nb == 36)
        begin
          ok = 1'b1;
          for (int i = 0; i < 10; i++)
            ok &= sh[35-2*i -: 2] == local_codes[2*i +: 2];
          // A mismatch leaves data_out untouched
          if (ok)
            for (int j = 0; j < 8; j++)
              data_out[j] <= sh[15-2*j -: 2] == 2'h3;
          match <= ok;
          words <= words + 8'h01;
          last_word <= sh;
        end
      end
    end
  end
endmodule

// ==== verif/tb_top.sv ====
// Purpose: Self-checking bench for the tri-state encoder.
// Assumes: Shortened slot and settle counts; floating lines follow the probe.
// Notes:   Line modes are 0 low, 1 high, 2 floating, two bits per line.
`timescale 1ns/1ps
module tb_top;
  localparam int SLOT = 4;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        send_gate = 1'b0;
  logic [35:0] modes = 36'h584964261;
  logic [35:0] old;
  logic [17:0] lines = 18'h00000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready, pslverr, pull_probe, rf_output, err, match;
  logic [19:0] rx_codes = 20'h00000;
  logic [7:0]  rx_data, words, keep;
  logic [35:0] last_word;
  int          fail_count = 0;
  int          tests_run = 0;
  int          cyc = 0;

  tristate_address_data_encoder #(.SLOT_DIV(SLOT), .SETTLE(8)) u_tristate_address_data_encoder (
    .mclk(mclk), .reset(reset), .send_gate(send_gate), .code_select_lines(lines[9:0]),
    .payload_inputs(lines[17:10]), .pull_probe(pull_probe), .rf_output(rf_output),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  rx_decoder_model #(.SLOT(SLOT)) u_rx_decoder_model (
    .mclk(mclk), .reset(reset), .rf_in(rf_output), .local_codes(rx_codes),
    .match(match), .data_out(rx_data), .words(words), .last_word(last_word));

  initial
    forever #12.5 mclk = ~mclk;

  // Floating lines lag the probe by one edge, well inside the settle time
  always @(posedge mclk)
    for (int i = 0; i < 18; i++)
      lines[i] <= (modes[2*i +: 2] == 2'h2) ? pull_probe : modes[2*i];

  // ****************
  // Helpers
  // ****************
  function automatic logic [1:0] code(input logic [1:0] md);
    return (md == 2'h1) ? 2'h3 : ((md == 2'h2) ? 2'h1 : 2'h0);
  endfunction
  function automatic logic [35:0] codes(input logic [35:0] md);
    for (int i = 0; i < 18; i++)
      codes[2*i +: 2] = code(md[2*i +: 2]);
  endfunction
  function automatic logic [35:0] word(input logic [35:0] md);
    for (int i = 0; i < 18; i++)
      word[35-2*i -: 2] = code(md[2*i +: 2]);
  endfunction
  function automatic logic [7:0] dout(input logic [35:0] md);
    for (int j = 0; j < 8; j++)
      dout[j] = md[20+2*j +: 2] == 2'h1;
  endfunction

  task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_words(input int n);
    while (words < n)
      @(posedge mclk);
  endtask

  task automatic results;
    if (fail_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      fail_count++;
      results();
    end
  end

  // ****************
  // Scenarios
  // ****************
  initial
  begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    apb(1'b0, encoder_pkg::OFS_CTRL, 32'h0);
    chk("ctrl", encoder_pkg::CTRL_RESET, rd);
    apb(1'b0, encoder_pkg::OFS_STATUS, 32'h0);
    chk("status", 36'h0, rd);
    apb(1'b1, 12'h020, 32'hFFFFFFFF);
    chk("bad write", 36'h1, err);
    apb(1'b0, 12'h020, 32'h0);
    chk("bad read", 36'h1, {rd, err});
    apb(1'b1, encoder_pkg::OFS_CYCLES, 32'h5);
    apb(1'b0, encoder_pkg::OFS_CYCLES, 32'h0);
    chk("cycles ro", 36'h0, rd);
    // Gate drops in the last bit of the first word: the cycle must still end whole
    rx_codes <= 20'(codes(modes));
    send_gate <= 1'b1;
    wait_words(1);
    send_gate <= 1'b0;
    wait_words(3);
    chk("word", word(modes), last_word);
    chk("rx data", {1'b1, dout(modes)}, {match, rx_data});
    repeat (3000) @(posedge mclk);
    chk("stopped", 36'h3, words);
    apb(1'b0, encoder_pkg::OFS_CYCLES, 32'h0);
    chk("cycles", 36'h1, rd);
    apb(1'b0, encoder_pkg::OFS_ADDR_TRITS, 32'h0);
    chk("addr trits", 20'(codes(modes)), rd);
    apb(1'b0, encoder_pkg::OFS_DATA_TRITS, 32'h0);
    chk("data trits", codes(modes) >> 20, rd);
    // Data changed mid-cycle shows only from the next cycle
    send_gate <= 1'b1;
    wait_words(4);
    old = modes;
    modes[35:20] <= 16'h1094;
    wait_words(6);
    chk("old data", word(old), last_word);
    wait_words(7);
    send_gate <= 1'b0;
    chk("new data", word(modes), last_word);
    wait_words(9);
    chk("rx new", {1'b1, dout(modes)}, {match, rx_data});
    // Local address line 0 floating against a driven high
    keep = rx_data;
    rx_codes[1:0] <= 2'h1;
    modes[35:20] <= 16'h5555;
    send_gate <= 1'b1;
    wait_words(10);
    send_gate <= 1'b0;
    wait_words(12);
    chk("mismatch", {1'b0, keep}, {match, rx_data});
    // Soft gate with the serializer held: buffer fills, nothing lost
    rx_codes <= 20'(codes(modes));
    apb(1'b1, encoder_pkg::OFS_CTRL, 32'h3);
    repeat (1000) @(posedge mclk);
    apb(1'b0, encoder_pkg::OFS_STATUS, 32'h0);
    chk("held", 36'h3, {rd[5], rd[0]});
    apb(1'b0, encoder_pkg::OFS_CTRL, 32'h0);
    chk("ctrl rb", 36'h3, rd);
    apb(1'b1, encoder_pkg::OFS_CTRL, 32'h1);
    wait_words(13);
    apb(1'b1, encoder_pkg::OFS_CTRL, 32'h0);
    wait_words(15);
    chk("after hold", {1'b1, dout(modes)}, {match, rx_data});
    // Power loss mid-cycle, then power-up with the gate tied high
    send_gate <= 1'b1;
    wait_words(16);
    reset <= 1'b1;
    repeat (5) @(posedge mclk);
    chk("power off", 36'h0, {rf_output, words});
    reset <= 1'b0;
    wait_words(1);
    chk("power up", word(modes), last_word);
    send_gate <= 1'b0;
    wait_words(3);
    results();
  end
endmodule
